// ==== rtl/dbgcs_top.sv ====
// Debugger control and status registers with command byte interface
`timescale 1ns/1ps
`include "dbgcs_defs.svh"

// Summary of operation
// - Writing 81H resets, then stays halted
// - Writing 41H resets, then runs
// - Writing 40H in debug resumes running
// - Control bit 7 halts fetch, resets 0
// - Bit 6 clear makes breakpoint a no-op
// - Enabled breakpoint sets halt bit itself
// - Bit 5 sends FFH on breakpoint
// - Status bit 6 shows halt mode
// - Status bit 7 shows debug mode
// - Status bit 5 zero under read protect
// - Read protect: halt bit cannot clear
// - Commands 04H write, 05H read, 02H status
module dbgcs_top #(
  parameter int RST_CYCLES = `DBGCS_SYSRST_CYCLES
) (
  input  wire logic                   SYS_CLK_IN,
  input  wire logic                   ARST_N_IN,
  input  wire dbgcs_pkg::dbgcs_byte_s CMD_IN,
  input  wire logic                   TX_READY_IN,
  input  wire logic                   BRK_DECODE_IN,
  input  wire logic                   CPU_HALT_IN,
  input  wire logic                   READ_PROTECT_IN,
  output dbgcs_pkg::dbgcs_byte_s      TX_OUT,
  output logic                        CPU_STOP_FETCH_OUT,
  output logic                        BRK_AS_NOP_OUT,
  output logic                        DEVICE_RESET_OUT
);
  import dbgcs_pkg::*;

  // Refuse reset lengths the sequencer counter cannot hold
  if (RST_CYCLES < 1 || RST_CYCLES > 65535) begin : g_bad_rst_cycles
    $error("dbgcs_top: RST_CYCLES out of range");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    dbgcs_state_e state;
    dbgcs_ctl_s   ctl;
    dbgcs_byte_s  tx;
    logic [7:0]   resp;
    logic         ack_pend;
    logic         stop;
    logic         nop;
    logic         devrst;
  } dbgcs_top_s;

  dbgcs_top_s st_r;
  dbgcs_top_s st_nxt;

  logic       seq_busy;
  logic       seq_done;
  logic       seq_start;
  logic [7:0] status_val;
  dbgcs_ctl_s wr_ctl;

  // --------------------------------------------------------------------------
  // Reset sequencer
  // --------------------------------------------------------------------------
  dbgcs_rst_seq #(
    .CYCLES (RST_CYCLES)
  ) u_rst_seq (
    .clk_in    (SYS_CLK_IN),
    .arst_n_in (ARST_N_IN),
    .start_in  (seq_start),
    .busy_out  (seq_busy),
    .done_out  (seq_done)
  );

  // Reset starts while the control reset bit is set and the sequencer is idle
  assign seq_start = st_r.ctl.rst && !seq_busy && !seq_done;

  // Status word assembly
  always_comb begin
    status_val                       = `DBGCS_STAT_RESET;
    status_val[`DBGCS_STAT_DBG_BIT]  = st_r.ctl.halt;
    status_val[`DBGCS_STAT_HALT_BIT] = CPU_HALT_IN;
    status_val[`DBGCS_STAT_RPI_BIT]  = !READ_PROTECT_IN;
  end

  // Write data as it lands in the control register
  always_comb begin
    wr_ctl        = dbgcs_ctl_s'(CMD_IN.data);
    wr_ctl.rsvd   = 4'h0;
    if (READ_PROTECT_IN && st_r.ctl.halt) begin
      wr_ctl.halt = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Byte handshake toward the link
    if (st_r.tx.valid && TX_READY_IN) begin
      st_nxt.tx.valid = 1'b0;
    end
    case (st_r.state)
      DBGCS_IDLE: begin
        if (CMD_IN.valid) begin
          case (CMD_IN.data)
            `DBGCS_CMD_WR_CONTROL: st_nxt.state = DBGCS_WDATA;
            `DBGCS_CMD_RD_CONTROL: begin
              st_nxt.resp  = st_r.ctl;
              st_nxt.state = DBGCS_RESP;
            end
            `DBGCS_CMD_RD_STATUS: begin
              st_nxt.resp  = status_val;
              st_nxt.state = DBGCS_RESP;
            end
            default: st_nxt.state = DBGCS_IDLE;
          endcase
        end
      end
      DBGCS_WDATA: begin
        if (CMD_IN.valid) begin
          st_nxt.ctl   = wr_ctl;
          st_nxt.state = DBGCS_IDLE;
        end
      end
      DBGCS_RESP: begin
        if (!st_nxt.tx.valid && !st_r.ack_pend) begin
          st_nxt.tx.valid = 1'b1;
          st_nxt.tx.data  = st_r.resp;
          st_nxt.state    = DBGCS_IDLE;
        end
      end
      default: st_nxt.state = DBGCS_IDLE;
    endcase
    // Pending acknowledge byte takes the transmitter first
    if (st_r.ack_pend && !st_nxt.tx.valid) begin
      st_nxt.tx.valid = 1'b1;
      st_nxt.tx.data  = `DBGCS_ACK_BYTE;
      st_nxt.ack_pend = 1'b0;
    end
    // Breakpoint: halt only when enabled; a new one outranks the send
    if (BRK_DECODE_IN && st_r.ctl.brk_en) begin
      st_nxt.ctl.halt = 1'b1;
      if (st_r.ctl.ack_en) begin
        st_nxt.ack_pend = 1'b1;
      end
    end
    // Reset bit clears itself when the sequence ends
    if (seq_done) begin
      st_nxt.ctl.rst = 1'b0;
    end
    st_nxt.stop   = st_nxt.ctl.halt;
    st_nxt.nop    = !st_nxt.ctl.brk_en;
    st_nxt.devrst = seq_start || (seq_busy && !seq_done);
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_r       <= '0;
      st_r.state <= DBGCS_IDLE;
      st_r.ctl   <= dbgcs_ctl_s'(`DBGCS_CTL_RESET);
      st_r.nop   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign TX_OUT             = st_r.tx;
  assign CPU_STOP_FETCH_OUT = st_r.stop;
  assign BRK_AS_NOP_OUT     = st_r.nop;
  assign DEVICE_RESET_OUT   = st_r.devrst;

endmodule : dbgcs_top

// ==== rtl/dbgcs_defs.svh ====
// Command codes, field positions, reset values and timing counts of the debug register block
`ifndef DBGCS_DEFS_SVH
`define DBGCS_DEFS_SVH

// ----------------------------------------------------------------------------
// Debugger command codes
// ----------------------------------------------------------------------------
`define DBGCS_CMD_RD_STATUS  8'h02
`define DBGCS_CMD_WR_CONTROL 8'h04
`define DBGCS_CMD_RD_CONTROL 8'h05

// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define DBGCS_CTL_HALT_BIT   7
`define DBGCS_CTL_BREAKPOINT_ENABLE_BIT  6
`define DBGCS_CTL_ACKEN_BIT  5
`define DBGCS_CTL_RST_BIT    0

// ----------------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------------
`define DBGCS_STAT_DBG_BIT   7
`define DBGCS_STAT_HALT_BIT  6
`define DBGCS_STAT_RPI_BIT   5

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define DBGCS_CTL_RESET      8'h00
`define DBGCS_STAT_RESET     8'h00
`define DBGCS_ACK_BYTE       8'hff
`define DBGCS_BRK_OPCODE     8'h00
`define DBGCS_SYSRST_CYCLES  16

`endif

// ==== rtl/dbgcs_pkg.sv ====
// Types shared by the debug control and status register block
package dbgcs_pkg;

  // --------------------------------------------------------------------------
  // Command decoder states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    DBGCS_IDLE  = 3'b001,
    DBGCS_WDATA = 3'b010,
    DBGCS_RESP  = 3'b100
  } dbgcs_state_e;

  // Byte channel to and from the serial link
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dbgcs_byte_s;

  // Control register fields
  typedef struct packed {
    logic       halt;
    logic       brk_en;
    logic       ack_en;
    logic [3:0] rsvd;
    logic       rst;
  } dbgcs_ctl_s;

endpackage : dbgcs_pkg

// ==== rtl/dbgcs_rst_seq.sv ====
// Device reset sequencer driven by the control reset bit
`timescale 1ns/1ps

module dbgcs_rst_seq #(
  parameter int CYCLES = 16
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out
);

  // Refuse counts that the 16-bit down counter cannot hold
  if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cycles
    $error("dbgcs_rst_seq: CYCLES out of range");
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } dbgcs_seq_s;

  dbgcs_seq_s st_r;
  dbgcs_seq_s st_nxt;

  // Count out the reset, pulse done at its end
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (st_r.busy) begin
      if (st_r.cnt == 16'h0001) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.cnt  = 16'h0000;
      end else begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
      end
    end else if (start_in) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = 16'(CYCLES);
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_out = st_r.busy;
  assign done_out = st_r.done;

endmodule : dbgcs_rst_seq

// ==== sim/dbgcs_properties.sv ====
// Port checker for the debug register block
`timescale 1ns/1ps
module dbgcs_properties #(parameter int RST_CYCLES = 16) (
  input wire logic                   SYS_CLK_IN,
  input wire logic                   ARST_N_IN,
  input wire dbgcs_pkg::dbgcs_byte_s CMD_IN,
  input wire logic                   TX_READY_IN,
  input wire logic                   BRK_DECODE_IN,
  input wire logic                   CPU_HALT_IN,
  input wire logic                   READ_PROTECT_IN,
  input wire dbgcs_pkg::dbgcs_byte_s TX_OUT,
  input wire logic                   CPU_STOP_FETCH_OUT,
  input wire logic                   BRK_AS_NOP_OUT,
  input wire logic                   DEVICE_RESET_OUT
);
  import dbgcs_pkg::*;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  logic [7:0] len_r;
  logic       wr_r;
  // Reset pulse length and pending data byte
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      len_r <= 8'h00;
      wr_r  <= 1'b0;
    end else begin
      len_r <= DEVICE_RESET_OUT ? len_r + 8'h01 : 8'h00;
      if (CMD_IN.valid) wr_r <= !wr_r && CMD_IN.data == 8'h04;
    end
  end
  // Control write and register read requests
  sequence s_wr(logic [7:0] v);
    CMD_IN.valid && !wr_r && CMD_IN.data == 8'h04 ##1 CMD_IN.valid && CMD_IN.data == v;
  endsequence
  sequence s_rd;
    CMD_IN.valid && !wr_r && !TX_OUT.valid && (CMD_IN.data == 8'h05 || CMD_IN.data == 8'h02);
  endsequence
  chk_read_reply: assert property (s_rd |-> ##[2:3] TX_OUT.valid)
    else $error("read gave no reply");
  chk_tx_hold: assert property (TX_OUT.valid && !TX_READY_IN |=> TX_OUT.valid && $stable(TX_OUT.data))
    else $error("reply byte dropped");
  chk_reset_stop: assert property (s_wr(8'h81) |-> ##[1:2] DEVICE_RESET_OUT && CPU_STOP_FETCH_OUT)
    else $error("reset and stop failed");
  chk_reset_go: assert property (s_wr(8'h41) |-> ##[1:2] DEVICE_RESET_OUT && !CPU_STOP_FETCH_OUT)
    else $error("reset and go failed");
  chk_run_write: assert property (s_wr(8'h40) ##0 !READ_PROTECT_IN |-> ##2 !CPU_STOP_FETCH_OUT)
    else $error("run write failed");
  chk_reset_len: assert property ($fell(DEVICE_RESET_OUT) |-> len_r == RST_CYCLES + 1)
    else $error("reset length wrong");
  chk_brk_halt: assert property (BRK_DECODE_IN && !BRK_AS_NOP_OUT |-> ##2 CPU_STOP_FETCH_OUT)
    else $error("breakpoint did not halt");
  chk_protect_hold: assert property (READ_PROTECT_IN && CPU_STOP_FETCH_OUT |=> CPU_STOP_FETCH_OUT)
    else $error("halt cleared under protect");
endmodule : dbgcs_properties

bind dbgcs_top dbgcs_properties #(.RST_CYCLES(RST_CYCLES)) u_dbgcs_properties (
  .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .CMD_IN(CMD_IN), .TX_READY_IN(TX_READY_IN),
  .BRK_DECODE_IN(BRK_DECODE_IN), .CPU_HALT_IN(CPU_HALT_IN), .READ_PROTECT_IN(READ_PROTECT_IN),
  .TX_OUT(TX_OUT), .CPU_STOP_FETCH_OUT(CPU_STOP_FETCH_OUT), .BRK_AS_NOP_OUT(BRK_AS_NOP_OUT),
  .DEVICE_RESET_OUT(DEVICE_RESET_OUT));

// ==== sim/dbgcs_host_model.sv ====
// Host tool model taking reply bytes off the link
`timescale 1ns/1ps
module dbgcs_host_model (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic stall_in,
  input  wire logic tx_valid_in,
  output logic      ready_out
);
  // Accept offered replies late, or later still when stalled
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) ready_out <= 1'b0;
    else ready_out <= !stall_in && tx_valid_in;
  end
endmodule : dbgcs_host_model

// ==== sim/tb.sv ====
// Self-checking bench for the debug control and status registers
`timescale 1ns/1ps
module tb;
  import dbgcs_pkg::*;
  logic clk = 0, arst_n = 0, tx_rdy, breakpoint_opcode = 0, halt = 0, prot = 0, stall = 0;
  logic stop, nop, devrst;
  dbgcs_byte_s cmd = '0;
  dbgcs_byte_s tx;
  localparam int RST_C = 2;
  int fails = 0, checked = 0, seed = 17791, n, rst_len = 0;
  logic [7:0] exp_q[$];
  always #5 clk = ~clk;
  dbgcs_top #(.RST_CYCLES(RST_C)) u_dbgcs_top (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .CMD_IN(cmd),
    .TX_READY_IN(tx_rdy), .BRK_DECODE_IN(breakpoint_opcode), .CPU_HALT_IN(halt), .READ_PROTECT_IN(prot),
    .TX_OUT(tx), .CPU_STOP_FETCH_OUT(stop), .BRK_AS_NOP_OUT(nop), .DEVICE_RESET_OUT(devrst));
  dbgcs_host_model u_dbgcs_host_model (.clk_in(clk), .arst_n_in(arst_n), .stall_in(stall),
    .tx_valid_in(tx.valid), .ready_out(tx_rdy));
  // ---------------------------------------------------------------
  // Checking and link tasks
  // ---------------------------------------------------------------
  task automatic check(string w, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task automatic stop_test();
    $display("Mismatches %0d comparisons %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic drain();
    n = 0;
    while (exp_q.size() > 0 && n < 60) begin
      tick(1);
      n++;
    end
    if (exp_q.size() > 0) begin
      fails++;
      stop_test();
    end
    tick(2);
  endtask : drain
  task automatic wr(logic [7:0] v);
    cmd = '{1'b1, 8'h04};
    tick(1);
    cmd = '{1'b1, v};
    tick(1);
    cmd = '0;
    tick(8);
  endtask : wr
  task automatic rd(logic [7:0] op, logic [7:0] e);
    exp_q.push_back(e);
    cmd = '{1'b1, op};
    tick(1);
    cmd = '0;
    drain();
  endtask : rd
  task automatic pulse_brk();
    breakpoint_opcode = 1'b1;
    tick(1);
    breakpoint_opcode = 1'b0;
    tick(4);
  endtask : pulse_brk
  // Random host stalls; every reply byte meets the oldest note
  always @(posedge clk) begin
    stall <= #1 1'($random(seed));
    if (devrst) rst_len++;
    if (tx.valid && tx_rdy) check("reply", tx.data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  end
  // Main sequence
  initial begin
    tick(6);
    check("reset out", {5'h0, nop, stop, devrst}, 8'h04);
    arst_n = 1'b1;
    rd(8'h05, 8'h00);
    rd(8'h02, 8'h20);
    wr(8'h81);
    check("stop", {7'h0, stop}, 8'h01);
    check("reset len", 8'(rst_len), 8'(RST_C + 1));
    check("reset end", {7'h0, devrst}, 8'h00);
    rd(8'h05, 8'h80);
    halt = 1'($random(seed));
    rd(8'h02, {1'b1, halt, 6'h20});
    wr(8'h40);
    check("nop", {6'h0, nop, stop}, 8'h00);
    rst_len = 0;
    wr(8'h41);
    check("reset len", 8'(rst_len), 8'(RST_C + 1));
    rd(8'h05, 8'h40);
    wr(8'h60);
    exp_q.push_back(8'hff);
    pulse_brk();
    drain();
    check("brk halt", {7'h0, stop}, 8'h01);
    wr(8'h5e);
    rd(8'h05, 8'h40);
    pulse_brk();
    rd(8'h05, 8'hc0);
    wr(8'h00);
    pulse_brk();
    check("brk nop", {6'h0, nop, stop}, 8'h02);
    wr(8'h80);
    prot = 1'b1;
    wr(8'h00);
    rd(8'h05, 8'h80);
    rd(8'h02, {1'b1, halt, 6'h00});
    stop_test();
  end
endmodule : tb
